/* File: hdl/clk_divider.sv */
`timescale 1ns/1ps
// Makes the memory clock from the system clock; the half period is in system cycles.
module clk_divider #(
  parameter int DIV_W = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [DIV_W-1:0] half,
  output logic                  ck,
  output logic                  ck_n,
  output logic                  tick
);

  logic [DIV_W-1:0] cnt_r;
  logic             flip;

  // A half period of zero is treated as one so the clock never stalls.
  assign flip = (cnt_r >= half - 1'b1) || (half == '0);

  // Counter and clock pair; tick marks the system cycle of each rising edge.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      ck    <= 1'b0;
      ck_n  <= 1'b1;
      tick  <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (flip) begin
        cnt_r <= '0;
        ck    <= ~ck;
        ck_n  <= ck;
        tick  <= ~ck; // Rising edge of the memory clock.
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

endmodule

/* File: hdl/ddr_train_ctrl.sv */
`timescale 1ns/1ps
// Overview of operation
// - Clock frequency changes only while the memory sits in precharge power-down.
// - New clock runs stable for the exit interval before leaving the low-power state.
// - ODT stays low through a power-down frequency change.
// - Wait the entry interval after CKE falls; hold ODT and CKE low meanwhile.
// - Stable clock before power-down exit, then after exit delay reset DLL by MRS.
// - Reprogram latencies with CKE high; keep ODT low, CKE high during relock.
// - New clock stays within the speed grade's frequency limits.
// - Termination choice must suit the output buffer setting during leveling.
// - During leveling only NOP, deselect and the closing MRS are issued.
// - One rank levels at a time; other ranks disable outputs via bit 12.
// - ODT after mode delay; strobes driven low after strobe-enable delay.
// - Single strobe edge after settle; feedback read after output delay.
// - Adjust strobe delay per pulse; lock it on a 0 to 1 feedback change.
// - Each byte lane levels on its own from its own feedback bits.
// - Exit: release strobes, drop ODT, then clear leveling bit by MRS.
// - After the closing MRS wait mode delays before further commands.
module ddr_train_ctrl
  import wlfc_pkg::*;
#(
  parameter int               DIV_W     = 8,
  parameter int               DLY_W     = 4,
  parameter logic [DIV_W-1:0] HALF_INIT = 8'h04,
  parameter logic [DIV_W-1:0] HALF_MIN  = 8'h01,
  parameter logic [DIV_W-1:0] HALF_MAX  = 8'h10
) (
  input  wire logic                   SYS_CLK,
  input  wire logic                   RESET,
  input  wire logic                   CMD_VALID,
  input  wire logic                   CMD_OP,
  input  wire logic [DIV_W-1:0]       CMD_HALF,
  input  wire logic [AW-1:0]          CMD_MR0,
  input  wire logic [AW-1:0]          CMD_MR1,
  input  wire logic [AW-1:0]          CMD_MR2,
  input  wire timing_type             TIMING,
  output logic                        CMD_READY,
  output logic                        CMD_DONE,
  output logic                        CMD_ERR,
  output logic [LANES-1:0]            LOCKED,
  output logic                        FAIL,
  output logic [LANES*DLY_W-1:0]      DELAY,
  output logic                        DDR_CK,
  output logic                        DDR_CK_N,
  output logic                        DDR_CKE,
  output cmd_type                     DDR_CMD,
  output logic                        DDR_ODT,
  output logic [LANES-1:0]            DDR_DQS_O,
  output logic [LANES-1:0]            DDR_DQS_N_O,
  output logic [LANES-1:0]            DDR_DQS_OE_N,
  input  wire logic [DQ_W-1:0]        DDR_DQ_I
);

  localparam int PW = DLY_W + 2;
  localparam logic [PW-1:0] PULSE_SPAN = PW'((1 << DLY_W) + PULSE_LEN);
  localparam logic [PW-1:0] PLEN      = PW'(PULSE_LEN);
  localparam logic [DLY_W-1:0] DLY_MAX = '1;

  state_type        st_r;
  logic [TW-1:0]    tmr_r;
  logic [PW-1:0]    pcnt_r;
  logic [DIV_W-1:0] half_r;
  logic [DIV_W-1:0] half_new_r;
  logic             op_r;
  logic [AW-1:0]    mr0_r;
  logic [AW-1:0]    mr1_r;
  logic [AW-1:0]    mr2_r;
  timing_type       tm_r;
  logic [LANES-1:0] prev_r;
  logic [DLY_W-1:0] dly_r [LANES];
  logic             tick;
  logic             adv;
  logic             bad_half;
  logic [LANES-1:0] fb_raw;
  logic [LANES-1:0] fb;
  logic [LANES-1:0] hit;
  logic [LANES-1:0] ovf;
  logic             fin;
  logic             mrs_go;
  logic [2:0]       mrs_ba;
  logic [AW-1:0]    mrs_addr;

  // Memory clock; the controller makes it, so all link logic stays on SYS_CLK.
  clk_divider #(
    .DIV_W (DIV_W)
  ) u_div (
    .clk  (SYS_CLK),
    .rst  (RESET),
    .half (half_r),
    .ck   (DDR_CK),
    .ck_n (DDR_CK_N),
    .tick (tick)
  );

  // Feedback arrives asynchronously, one chosen bit per byte lane.
  genvar l;
  generate
    for (l = 0; l < LANES; l++) begin : g_fb
      assign fb_raw[l] = DDR_DQ_I[l*LANE_BITS];
      assign DELAY[l*DLY_W +: DLY_W] = dly_r[l];
    end
  endgenerate

  fb_sync #(
    .W (LANES)
  ) u_sync (
    .clk  (SYS_CLK),
    .rst  (RESET),
    .din  (fb_raw),
    .dout (fb)
  );

  // Waits end on the memory clock edge at which the timer has run out.
  assign adv      = tick && (tmr_r == '0);
  assign bad_half = (half_new_r < HALF_MIN) || (half_new_r > HALF_MAX);

  // Per-lane verdict from the current feedback sample.
  always_comb begin
    hit = '0;
    ovf = '0;
    for (int i = 0; i < LANES; i++) begin
      hit[i] = !LOCKED[i] && !prev_r[i] && fb[i];
      ovf[i] = !LOCKED[i] && !hit[i] && (dly_r[i] == DLY_MAX);
    end
    fin = (&(LOCKED | hit)) || (|ovf);
  end

  // Mode register writes; the leveling and DLL reset bits are forced here, the rest is the user's word.
  always_comb begin
    mrs_go   = 1'b0;
    mrs_ba   = BA_IDLE;
    mrs_addr = ADDR_IDLE;
    unique case (st_r)
      ST_START: begin
        mrs_go   = adv && (op_r == OP_LEVEL);
        mrs_ba   = BA_MR1;
        mrs_addr = mr1_r;
        mrs_addr[MR1_LEVEL_BIT] = 1'b1;
      end
      ST_PDX: begin
        mrs_go   = adv;
        mrs_ba   = BA_MR0;
        mrs_addr = mr0_r;
        mrs_addr[MR0_DLL_RESET_BIT] = 1'b1;
      end
      ST_DLLRST: begin
        mrs_go   = adv;
        mrs_ba   = BA_MR2;
        mrs_addr = mr2_r;
      end
      ST_WLEXIT: begin
        mrs_go   = adv;
        mrs_ba   = BA_MR1;
        mrs_addr = mr1_r;
        mrs_addr[MR1_LEVEL_BIT] = 1'b0;
      end
      default: begin
        mrs_go = 1'b0;
      end
    endcase
  end

  // Timer load: a count of n ends n memory clock edges later, and a count of zero after one.
  function automatic logic [TW-1:0] tload(input logic [TW-1:0] n);
    tload = (n == '0) ? '0 : n - 1'b1;
  endfunction

  // Sequencer state, wait timer and ready flag.
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      st_r      <= ST_IDLE;
      tmr_r     <= '0;
      CMD_READY <= 1'b1;
    end else begin
      if (tick && (tmr_r != '0)) begin
        tmr_r <= tmr_r - 1'b1;
      end
      unique case (st_r)
        ST_IDLE: if (CMD_VALID) begin
          st_r      <= ST_START;
          CMD_READY <= 1'b0;
        end
        ST_START: if (adv) begin
          if (op_r == OP_LEVEL) begin
            st_r  <= ST_WLENT;
            tmr_r <= tload(tm_r.tmod);
          end else if (bad_half) begin
            st_r      <= ST_IDLE;
            CMD_READY <= 1'b1;
          end else begin
            st_r  <= ST_PDE;
            tmr_r <= tload(tm_r.tcksre);
          end
        end
        ST_PDE: if (adv) begin
          st_r  <= ST_SWITCH;
          tmr_r <= tload(tm_r.tcksrx);
        end
        ST_SWITCH: if (adv) begin
          st_r  <= ST_PDX;
          tmr_r <= tload(tm_r.txp);
        end
        ST_PDX: if (adv) begin
          st_r  <= ST_DLLRST;
          tmr_r <= tload(tm_r.tmrd);
        end
        ST_DLLRST: if (adv) begin
          st_r  <= ST_MR2;
          tmr_r <= tload(tm_r.tmod);
        end
        ST_MR2: if (adv) begin
          st_r  <= ST_RELOCK;
          tmr_r <= tload(tm_r.tdllk);
        end
        ST_RELOCK: if (adv) begin
          st_r <= ST_FINAL;
        end
        ST_WLENT: if (adv) begin
          st_r  <= ST_ODTON;
          tmr_r <= tload(tm_r.twldqsen);
        end
        ST_ODTON: if (adv) begin
          st_r  <= ST_DQSEN;
          tmr_r <= tload(tm_r.twlmrd);
        end
        ST_DQSEN: if (adv) begin
          st_r <= ST_PULSE;
        end
        ST_PULSE: if (pcnt_r == PULSE_SPAN - 1'b1) begin
          st_r  <= ST_FEEDBK;
          tmr_r <= tm_r.twlo; // One spare edge covers the partial first cycle.
        end
        ST_FEEDBK: if (adv) begin
          if (fin) begin
            st_r  <= ST_WLEXIT;
            tmr_r <= tload(tm_r.taof);
          end else begin
            st_r  <= ST_DQSEN;
            tmr_r <= tload(tm_r.twlmrd);
          end
        end
        ST_WLEXIT: if (adv) begin
          st_r  <= ST_WLOFF;
          tmr_r <= tload(tm_r.tmod);
        end
        ST_WLOFF: if (adv) begin
          st_r <= ST_FINAL;
        end
        ST_FINAL: begin
          st_r      <= ST_IDLE;
          CMD_READY <= 1'b1;
        end
      endcase
    end
  end

  // Request capture; the words are held for the whole sequence.
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      op_r       <= OP_FREQ;
      half_new_r <= HALF_INIT;
      mr0_r      <= ADDR_IDLE;
      mr1_r      <= ADDR_IDLE;
      mr2_r      <= ADDR_IDLE;
      tm_r       <= '0;
    end else if ((st_r == ST_IDLE) && CMD_VALID) begin
      op_r       <= CMD_OP;
      half_new_r <= CMD_HALF;
      mr0_r      <= CMD_MR0;
      mr1_r      <= CMD_MR1;
      mr2_r      <= CMD_MR2;
      tm_r       <= TIMING;
    end
  end

  // Divider ratio changes only once power-down has settled, never elsewhere.
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      half_r <= HALF_INIT;
    end else if ((st_r == ST_PDE) && adv) begin
      half_r <= half_new_r;
    end
  end

  // Command pins last one memory clock; everything else is NOP.
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      DDR_CMD <= {CMD_NOP, BA_IDLE, ADDR_IDLE};
    end else if (tick) begin
      if (mrs_go) begin
        DDR_CMD <= {CMD_MRS, mrs_ba, mrs_addr};
      end else begin
        DDR_CMD <= {CMD_NOP, BA_IDLE, ADDR_IDLE};
      end
    end
  end

  // CKE falls to enter power-down and rises after the new clock has settled.
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      DDR_CKE <= 1'b1;
    end else if ((st_r == ST_START) && adv && (op_r == OP_FREQ) && !bad_half) begin
      DDR_CKE <= 1'b0;
    end else if ((st_r == ST_SWITCH) && adv) begin
      DDR_CKE <= 1'b1;
    end
  end

  // ODT is raised only inside leveling, so frequency changes and relock see it low.
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      DDR_ODT <= 1'b0;
    end else if ((st_r == ST_WLENT) && adv) begin
      DDR_ODT <= 1'b1;
    end else if ((st_r == ST_FEEDBK) && adv && fin) begin
      DDR_ODT <= 1'b0;
    end
  end

  // Pulse phase counter in system cycles, giving the strobe delay its resolution.
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      pcnt_r <= '0;
    end else if (st_r == ST_PULSE) begin
      pcnt_r <= pcnt_r + 1'b1;
    end else begin
      pcnt_r <= '0;
    end
  end

  // Strobes: driven low from strobe enable, one delayed high pulse per lane, released on exit.
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      DDR_DQS_O    <= '0;
      DDR_DQS_N_O  <= '1;
      DDR_DQS_OE_N <= '1;
    end else begin
      if ((st_r == ST_ODTON) && adv) begin
        DDR_DQS_OE_N <= '0;
      end else if ((st_r == ST_FEEDBK) && adv && fin) begin
        DDR_DQS_OE_N <= '1;
      end
      for (int i = 0; i < LANES; i++) begin
        if ((st_r == ST_PULSE) && (pcnt_r >= PW'(dly_r[i])) && (pcnt_r < PW'(dly_r[i]) + PLEN)) begin
          DDR_DQS_O[i]   <= 1'b1;
          DDR_DQS_N_O[i] <= 1'b0;
        end else begin
          DDR_DQS_O[i]   <= 1'b0;
          DDR_DQS_N_O[i] <= 1'b1;
        end
      end
    end
  end

  // Per-lane search; the previous sample starts at one so stale data cannot fake a rise.
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      LOCKED <= '0;
      FAIL   <= 1'b0;
      prev_r <= '1;
      for (int i = 0; i < LANES; i++) begin
        dly_r[i] <= '0;
      end
    end else if ((st_r == ST_START) && adv && (op_r == OP_LEVEL)) begin
      LOCKED <= '0;
      FAIL   <= 1'b0;
      prev_r <= '1;
      for (int i = 0; i < LANES; i++) begin
        dly_r[i] <= '0;
      end
    end else if ((st_r == ST_FEEDBK) && adv) begin
      FAIL <= |ovf;
      for (int i = 0; i < LANES; i++) begin
        if (!LOCKED[i]) begin
          prev_r[i] <= fb[i];
          if (hit[i]) begin
            LOCKED[i] <= 1'b1;
          end else if (!ovf[i]) begin
            dly_r[i] <= dly_r[i] + 1'b1;
          end
        end
      end
    end
  end

  // Completion and refusal pulses.
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      CMD_DONE <= 1'b0;
      CMD_ERR  <= 1'b0;
    end else begin
      CMD_DONE <= (st_r == ST_FINAL);
      CMD_ERR  <= (st_r == ST_START) && adv && (op_r == OP_FREQ) && bad_half;
    end
  end

endmodule

/* File: hdl/fb_sync.sv */
`timescale 1ns/1ps
// Three-stage synchroniser; a change counts once stages two and three agree.
module fb_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic [W-1:0]      dout
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // The first stage feeds only the second, to keep metastability contained.
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          s1_r[i] <= 1'b0;
          s2_r[i] <= 1'b0;
          s3_r[i] <= 1'b0;
          dout[i] <= 1'b0;
        end else begin
          s1_r[i] <= din[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          if (s2_r[i] == s3_r[i]) begin
            dout[i] <= s3_r[i];
          end
        end
      end
    end
  endgenerate

endmodule

/* File: hdl/wlfc_pkg.sv */
package wlfc_pkg;

  // Widths of the timing counts, byte lanes, data pins and address pins.
  localparam int TW        = 10;
  localparam int LANES     = 2;
  localparam int LANE_BITS = 8;
  localparam int DQ_W      = LANES * LANE_BITS;
  localparam int AW        = 14;

  // Strobe pulse length in system clock cycles.
  localparam int PULSE_LEN = 4;

  // Command pin codes as {cs_n, ras_n, cas_n, we_n}.
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_MRS = 4'h0;

  // Mode register selects on the bank pins.
  localparam logic [2:0] BA_MR0 = 3'h0;
  localparam logic [2:0] BA_MR1 = 3'h1;
  localparam logic [2:0] BA_MR2 = 3'h2;

  // Field positions inside the mode register words.
  localparam int MR0_DLL_RESET_BIT = 8;
  localparam int MR1_LEVEL_BIT     = 7;
  localparam int MR1_QOFF_BIT      = 12;

  // Operation codes on the user port.
  localparam logic OP_FREQ  = 1'b0;
  localparam logic OP_LEVEL = 1'b1;

  // Reset value of the address and bank pins.
  localparam logic [AW-1:0] ADDR_IDLE = 14'h0000;
  localparam logic [2:0]    BA_IDLE   = 3'h0;

  // All intervals, counted in memory clock cycles.
  typedef struct packed {
    logic [TW-1:0] tcksre;
    logic [TW-1:0] tcksrx;
    logic [TW-1:0] txp;
    logic [TW-1:0] tmod;
    logic [TW-1:0] tmrd;
    logic [TW-1:0] twldqsen;
    logic [TW-1:0] twlmrd;
    logic [TW-1:0] twlo;
    logic [TW-1:0] taof;
    logic [TW-1:0] tdllk;
  } timing_type;

  // Command pins towards the memory, sampled on the falling memory clock.
  typedef struct packed {
    logic          cs_n;
    logic          ras_n;
    logic          cas_n;
    logic          we_n;
    logic [2:0]    ba;
    logic [AW-1:0] addr;
  } cmd_type;

  typedef enum logic [15:0] {
    ST_IDLE   = 16'h0001,
    ST_START  = 16'h0002,
    ST_PDE    = 16'h0004,
    ST_SWITCH = 16'h0008,
    ST_PDX    = 16'h0010,
    ST_DLLRST = 16'h0020,
    ST_MR2    = 16'h0040,
    ST_RELOCK = 16'h0080,
    ST_WLENT  = 16'h0100,
    ST_ODTON  = 16'h0200,
    ST_DQSEN  = 16'h0400,
    ST_PULSE  = 16'h0800,
    ST_FEEDBK = 16'h1000,
    ST_WLEXIT = 16'h2000,
    ST_WLOFF  = 16'h4000,
    ST_FINAL  = 16'h8000
  } state_type;

endpackage

/* File: testbench/ddr_mem_model.sv */
`timescale 1ns/1ps
// Memory device seen from its pins; skews place each lane's view of CK off the system grid.
module ddr_mem_model
  import wlfc_pkg::*;
#(
  parameter int SKEW_LO = 5,
  parameter int SKEW_HI = 21,
  parameter int TWLO_NS = 20
) (
  input  wire logic             ck,
  input  wire cmd_type          cmd,
  input  wire logic             cke,
  input  wire logic             odt,
  input  wire logic [LANES-1:0] dqs,
  input  wire logic [LANES-1:0] dqs_oe_n,
  output logic      [DQ_W-1:0]  dq
);
  logic             level_r = 1'b0;
  logic [DQ_W-1:0]  fb_r = 16'h00ff;
  logic [LANES-1:0] ck_seen;
  logic             strobe_term;
  assign #(SKEW_LO) ck_seen[0] = ck;
  assign #(SKEW_HI) ck_seen[1] = ck;
  // Commands are held a whole CK, so the falling edge sees them without a race.
  always @(negedge ck) begin
    if (cke && !cmd.cs_n && !cmd.ras_n && !cmd.cas_n && !cmd.we_n && cmd.ba == BA_MR1) begin
      level_r <= cmd.addr[MR1_LEVEL_BIT];
    end
  end
  // Only the strobes are terminated in leveling; data termination stays off.
  assign strobe_term = level_r & odt;
  // Until the strobes are terminated the data pins keep changing.
  always @(ck) begin
    if (!strobe_term) begin
      fb_r <= ~fb_r;
    end
  end
  // Each lane samples its own view of CK and reports it on all its bits later.
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    always @(posedge dqs[l]) begin
      if (strobe_term && !dqs_oe_n[l]) begin
        fb_r[l*LANE_BITS +: LANE_BITS] <= #(TWLO_NS) {LANE_BITS{ck_seen[l]}};
      end
    end
  end
  assign dq = fb_r;
endmodule

/* File: testbench/ddr_train_ctrl_asserts.sv */
`timescale 1ns/1ps
// Pin-level ordering checks for the frequency change and leveling sequences.
module ddr_train_ctrl_asserts
  import wlfc_pkg::*;
#(
  parameter int               DIV_W    = 8,
  parameter logic [DIV_W-1:0] HALF_MIN = 8'h01,
  parameter logic [DIV_W-1:0] HALF_MAX = 8'h10
) (
  input wire logic             SYS_CLK,
  input wire logic             RESET,
  input wire logic             CMD_VALID,
  input wire logic             CMD_READY,
  input wire logic             CMD_OP,
  input wire logic [DIV_W-1:0] CMD_HALF,
  input wire logic             CMD_ERR,
  input wire logic [LANES-1:0] LOCKED,
  input wire logic             DDR_CK,
  input wire logic             DDR_CKE,
  input wire cmd_type          DDR_CMD,
  input wire logic             DDR_ODT,
  input wire logic [LANES-1:0] DDR_DQS_OE_N,
  input wire logic             DDR_CK_N,
  input wire logic [LANES-1:0] DDR_DQS_O,
  input wire logic [LANES-1:0] DDR_DQS_N_O
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  logic [8:0] run_r;
  logic [8:0] last_r;
  logic       cke_r;
  logic       ck_r;
  logic       mrs;
  assign mrs = !DDR_CMD.cs_n && !DDR_CMD.ras_n && !DDR_CMD.cas_n && !DDR_CMD.we_n;
  // Half period lengths; a run started by reset reads as zero so it is never compared.
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      run_r  <= 9'h000;
      last_r <= 9'h000;
      cke_r  <= 1'b0;
      ck_r   <= 1'b0;
    end else begin
      ck_r <= DDR_CK;
      if (DDR_CK != ck_r) begin
        run_r  <= 9'h001;
        last_r <= run_r;
        cke_r  <= DDR_CKE;
      end else begin
        run_r <= run_r + {8'h00, run_r != 9'h000};
      end
    end
  end
  property p_freq_hold;
    (DDR_CK != ck_r) && DDR_CKE && cke_r && last_r != 9'h000 |-> run_r == last_r;
  endproperty
  a_freq_hold: assert property (p_freq_hold) else $error("clock period moved with CKE high");
  property p_bad_half;
    CMD_VALID && CMD_READY && CMD_OP == OP_FREQ && (CMD_HALF < HALF_MIN || CMD_HALF > HALF_MAX)
      |=> DDR_CKE [*4] ##[0:100] (CMD_ERR && DDR_CKE);
  endproperty
  a_bad_half: assert property (p_bad_half) else $error("bad half period not refused");
  property p_odt_pd;
    !DDR_CKE |-> !DDR_ODT;
  endproperty
  a_odt_pd: assert property (p_odt_pd) else $error("ODT high in power-down");
  property p_cke_hold;
    $fell(DDR_CKE) |-> !DDR_CKE [*4];
  endproperty
  a_cke_hold: assert property (p_cke_hold) else $error("CKE low too briefly");
  property p_relock;
    $rose(DDR_CKE) |-> !DDR_ODT [*8];
  endproperty
  a_relock: assert property (p_relock) else $error("ODT raised during relock");
  property p_dll_mrs;
    mrs && DDR_CMD.ba == BA_MR0 |-> DDR_CMD.addr[MR0_DLL_RESET_BIT] && DDR_CKE;
  endproperty
  a_dll_mrs: assert property (p_dll_mrs) else $error("mode word zero without DLL reset");
  property p_wl_nop;
    DDR_DQS_OE_N != 2'b11 |-> !mrs && DDR_ODT;
  endproperty
  a_wl_nop: assert property (p_wl_nop) else $error("bad command or ODT while strobing");
  property p_wl_entry;
    mrs && DDR_CMD.ba == BA_MR1 |-> !DDR_ODT && DDR_DQS_OE_N == 2'b11;
  endproperty
  a_wl_entry: assert property (p_wl_entry) else $error("mode word one with ODT or strobes on");
  property p_release;
    $rose(&DDR_DQS_OE_N) |-> !DDR_ODT;
  endproperty
  a_release: assert property (p_release) else $error("ODT left high at strobe release");
  // The complement pins are never looked at by the bench, so they are checked here.
  property p_ck_pair;
    DDR_CK_N == !DDR_CK;
  endproperty
  a_ck_pair: assert property (p_ck_pair) else $error("clock pair not complementary");
  property p_dqs_pair;
    DDR_DQS_N_O == ~DDR_DQS_O;
  endproperty
  a_dqs_pair: assert property (p_dqs_pair) else $error("strobe pair not complementary");
  c_err: cover property (CMD_ERR);
  c_pd: cover property ($fell(DDR_CKE));
  c_lock: cover property ($rose(&LOCKED));
endmodule

/* File: testbench/test_ddr_train_ctrl.sv */
`timescale 1ns/1ps
// Drives requests on the falling edge and checks answers, mode words and clocks.
module test_ddr_train_ctrl;
  import wlfc_pkg::*;
  logic              SYS_CLK;
  logic              RESET;
  logic              CMD_VALID;
  logic              CMD_OP;
  logic [7:0]        CMD_HALF;
  logic [AW-1:0]     CMD_MR0;
  logic [AW-1:0]     CMD_MR1;
  logic [AW-1:0]     CMD_MR2;
  timing_type        TIMING;
  logic              CMD_READY;
  logic              CMD_DONE;
  logic              CMD_ERR;
  logic [1:0]        LOCKED;
  logic              FAIL;
  logic [7:0]        DELAY;
  logic              DDR_CK;
  logic              DDR_CKE;
  cmd_type           DDR_CMD;
  logic              DDR_ODT;
  logic [1:0]        DDR_DQS_O;
  logic [1:0]        DDR_DQS_OE_N;
  logic [DQ_W-1:0]   DDR_DQ_I;
  logic [AW-1:0]     mr_seen [8];
  logic [9:0]        rows [7] = '{10'h008, 10'h100, 10'h111, 10'h010, 10'h001, 10'h004, 10'h200};
  int                errors = 0;
  int                comparisons = 0;

  ddr_train_ctrl uut (.SYS_CLK(SYS_CLK), .RESET(RESET), .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP),
    .CMD_HALF(CMD_HALF), .CMD_MR0(CMD_MR0), .CMD_MR1(CMD_MR1), .CMD_MR2(CMD_MR2), .TIMING(TIMING),
    .CMD_READY(CMD_READY), .CMD_DONE(CMD_DONE), .CMD_ERR(CMD_ERR), .LOCKED(LOCKED), .FAIL(FAIL),
    .DELAY(DELAY), .DDR_CK(DDR_CK), .DDR_CK_N(), .DDR_CKE(DDR_CKE), .DDR_CMD(DDR_CMD), .DDR_ODT(DDR_ODT),
    .DDR_DQS_O(DDR_DQS_O), .DDR_DQS_N_O(), .DDR_DQS_OE_N(DDR_DQS_OE_N), .DDR_DQ_I(DDR_DQ_I));
  // An undriven strobe sits low behind its termination.
  ddr_mem_model mem (.ck(DDR_CK), .cmd(DDR_CMD), .cke(DDR_CKE), .odt(DDR_ODT),
    .dqs(DDR_DQS_O & ~DDR_DQS_OE_N), .dqs_oe_n(DDR_DQS_OE_N), .dq(DDR_DQ_I));

  initial begin
    SYS_CLK = 1'b0;
    forever #4 SYS_CLK = ~SYS_CLK;
  end
  // Records the last mode word written to each register.
  always @(negedge DDR_CK) begin
    if (!DDR_CMD.cs_n && !DDR_CMD.ras_n && !DDR_CMD.cas_n && !DDR_CMD.we_n) begin
      mr_seen[DDR_CMD.ba] <= DDR_CMD.addr;
    end
  end

  task automatic finish_test();
    if (errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic ok, input string what);
    comparisons++;
    if (ok !== 1'b1) begin
      errors++;
      $display("BAD %0t %s", $time, what);
    end
  endtask
  // Waits for READY, makes one request and waits a bounded time for its answer.
  task automatic run(input logic op, input logic [7:0] half, output logic done, output logic err);
    int n;
    n = 0;
    while (CMD_READY !== 1'b1 && n < 100) begin
      @(negedge SYS_CLK);
      n++;
    end
    CMD_OP = op;
    CMD_HALF = half;
    CMD_VALID = 1'b1;
    @(negedge SYS_CLK);
    CMD_VALID = 1'b0;
    done = 1'b0;
    err = 1'b0;
    while (!done && !err && n < 20000) begin
      @(negedge SYS_CLK);
      done = CMD_DONE === 1'b1;
      err = CMD_ERR === 1'b1;
      n++;
    end
    if (n >= 20000) begin
      errors++;
      $display("BAD %0t no answer", $time);
      finish_test();
    end
  endtask
  // Length in system cycles of one whole half period of the memory clock.
  task automatic half_len(output int n);
    logic c;
    for (int k = 0; k < 2; k++) begin
      c = DDR_CK;
      n = 0;
      while (DDR_CK === c && n < 99) begin
        @(negedge SYS_CLK);
        n++;
      end
    end
  endtask

  initial begin
    logic       op_x;
    logic       err_x;
    logic [7:0] half_x;
    logic       done;
    logic       err;
    int         n;
    RESET = 1'b1;
    CMD_VALID = 1'b0;
    CMD_OP = OP_FREQ;
    CMD_HALF = 8'h04;
    CMD_MR0 = 14'h0a50;
    CMD_MR1 = 14'h0004; // Single rank, buffer on, RZQ/4 termination.
    CMD_MR2 = 14'h0018;
    TIMING = {10{10'h003}};
    repeat (12) @(negedge SYS_CLK);
    check({CMD_READY, DDR_CKE, DDR_ODT, DDR_DQS_OE_N, LOCKED} === 7'h6c, "reset pins");
    RESET = 1'b0;
    // Rows are {op, refused, half}; the leveling row runs at a half period of four.
    for (int i = 0; i < 7; i++) begin
      {op_x, err_x, half_x} = rows[i];
      mr_seen = '{default: 14'h0000};
      run(op_x, half_x, done, err);
      check(err === err_x && done === !err_x, "answer kind");
      if (!err_x && !op_x) begin
        check(mr_seen[0] === (CMD_MR0 | 14'h0100), "DLL reset word");
        check(mr_seen[2] === CMD_MR2, "write latency word");
        half_len(n);
        check(n == half_x, "new clock period");
      end
      if (op_x) begin
        check(LOCKED === 2'b11 && FAIL === 1'b0, "lanes locked");
        check(((DELAY[7:4] - DELAY[3:0]) & 4'h7) === 4'h2, "lane delay gap");
        check(mr_seen[1] === CMD_MR1, "leveling exit word");
      end
    end
    // Reset in the middle of power-down must bring CKE back and the start-up clock.
    CMD_OP = OP_FREQ;
    CMD_HALF = 8'h08;
    CMD_VALID = 1'b1;
    @(negedge SYS_CLK);
    CMD_VALID = 1'b0;
    n = 0;
    while (DDR_CKE !== 1'b0 && n < 200) begin
      @(negedge SYS_CLK);
      n++;
    end
    check(DDR_CKE === 1'b0, "power-down entry");
    RESET = 1'b1;
    repeat (2) @(negedge SYS_CLK);
    check(DDR_CKE === 1'b1 && DDR_ODT === 1'b0 && CMD_READY === 1'b1, "reset in power-down");
    RESET = 1'b0;
    half_len(n);
    check(n == 4, "start-up clock period");
    finish_test();
  end
endmodule

bind ddr_train_ctrl ddr_train_ctrl_asserts #(.DIV_W(DIV_W), .HALF_MIN(HALF_MIN), .HALF_MAX(HALF_MAX)) chk (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .CMD_OP(CMD_OP),
  .CMD_HALF(CMD_HALF), .CMD_ERR(CMD_ERR), .LOCKED(LOCKED), .DDR_CK(DDR_CK), .DDR_CKE(DDR_CKE),
  .DDR_CMD(DDR_CMD), .DDR_ODT(DDR_ODT), .DDR_DQS_OE_N(DDR_DQS_OE_N), .DDR_CK_N(DDR_CK_N),
  .DDR_DQS_O(DDR_DQS_O), .DDR_DQS_N_O(DDR_DQS_N_O));
